//--- design/hcs_command_status.sv
// Host command and status register with soft reset sequencing
`timescale 1ns/100ps
module hcs_command_status (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_sel,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        sched_overrun,
  input  wire logic        handover_done,
  input  wire logic        bulk_list_start,
  input  wire logic        bulk_td_found,
  input  wire logic        control_list_start,
  input  wire logic        control_td_found,
  output logic             bulk_list_process,
  output logic             control_list_process,
  output logic             ownership_change_event,
  output logic             soft_reset_active,
  output logic             suspended_state
);
  import hcs_pkg::*;

  typedef enum {SR_IDLE, SR_BUSY} hcs_srst_type;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic wr_hit;
  assign wr_hit = reg_sel && reg_wr && (reg_addr == HCS_CMD_STATUS_OFF);

  // ----------------------------------------
  // Command bits
  // ----------------------------------------
  logic         ownership_change_request;
  logic         bulk_list_filled;
  logic         control_list_filled;
  logic         controller_soft_reset;
  logic         next_own_req;
  logic         next_bulk_filled;
  logic         next_ctrl_filled;
  logic         next_soft_reset;
  logic         next_blp;
  logic         next_clp;
  logic         next_susp;
  logic [1:0]   overrun_count;
  hcs_srst_type srst_state;
  hcs_srst_type next_srst_state;
  logic [9:0]   srst_cnt;
  logic [9:0]   next_srst_cnt;
  logic         srst_start;
  logic         srst_done;

  assign srst_start = wr_hit && reg_wdata[HCS_RESET_BIT] && (srst_state == SR_IDLE);
  assign srst_done  = (srst_state == SR_BUSY) && (srst_cnt == HCS_SRST_WORK);

  always_comb begin
    next_own_req     = ownership_change_request;
    next_bulk_filled = bulk_list_filled;
    next_ctrl_filled = control_list_filled;
    next_blp         = 1'b0;
    next_clp         = 1'b0;
    next_susp        = suspended_state;
    next_soft_reset  = controller_soft_reset;
    // Hardware clears first; software writes of one win same cycle, but soft reset completion clears them last
    if (handover_done) begin
      next_own_req = 1'b0;
    end
    if (bulk_list_start) begin
      next_blp         = bulk_list_filled;
      next_bulk_filled = 1'b0;
    end
    if (bulk_td_found) begin
      next_bulk_filled = 1'b1;
    end
    if (control_list_start) begin
      next_clp         = control_list_filled;
      next_ctrl_filled = 1'b0;
    end
    if (control_td_found) begin
      next_ctrl_filled = 1'b1;
    end
    // Writes of zero leave command bits alone; reserved bits dropped
    if (wr_hit) begin
      if (reg_wdata[HCS_OWN_REQ_BIT]) begin
        next_own_req = 1'b1;
      end
      if (reg_wdata[HCS_BULK_FILLED_BIT]) begin
        next_bulk_filled = 1'b1;
      end
      if (reg_wdata[HCS_CTRL_FILLED_BIT]) begin
        next_ctrl_filled = 1'b1;
      end
    end
    if (srst_start) begin
      next_soft_reset = 1'b1;
      next_susp       = 1'b1;
    end
    if (srst_done) begin
      // Operational bits return to reset; suspend state kept
      next_soft_reset  = 1'b0;
      next_own_req     = 1'b0;
      next_bulk_filled = 1'b0;
      next_ctrl_filled = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ownership_change_request <= 1'b0;
      bulk_list_filled         <= 1'b0;
      control_list_filled      <= 1'b0;
      controller_soft_reset    <= 1'b0;
      bulk_list_process        <= 1'b0;
      control_list_process     <= 1'b0;
      suspended_state          <= 1'b0;
    end else begin
      ownership_change_request <= next_own_req;
      bulk_list_filled         <= next_bulk_filled;
      control_list_filled      <= next_ctrl_filled;
      controller_soft_reset    <= next_soft_reset;
      bulk_list_process        <= next_blp;
      control_list_process     <= next_clp;
      suspended_state          <= next_susp;
    end
  end

  // ----------------------------------------
  // Soft reset sequencer
  // ----------------------------------------
  // Fixed short sequence, well inside the 10 us ceiling; no downstream reset
  always_comb begin
    next_srst_state = srst_state;
    next_srst_cnt   = srst_cnt;
    case (srst_state)
      SR_IDLE: begin
        next_srst_cnt = 10'h000;
        if (srst_start) begin
          next_srst_state = SR_BUSY;
        end
      end
      SR_BUSY: begin
        next_srst_cnt = srst_cnt + 10'h001;
        if (srst_done) begin
          next_srst_state = SR_IDLE;
          next_srst_cnt   = 10'h000;
        end
      end
      default: begin
        next_srst_state = SR_IDLE;
        next_srst_cnt   = 10'h000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_state <= SR_IDLE;
      srst_cnt   <= 10'h000;
    end else begin
      srst_state <= next_srst_state;
      srst_cnt   <= next_srst_cnt;
    end
  end

  assign soft_reset_active = controller_soft_reset;

  // ----------------------------------------
  // Overrun counter
  // ----------------------------------------
  // Steps on each overrun regardless of the status flag; soft reset completion in the same cycle clears it instead
  hcs_wrap_counter u_overrun (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (srst_done),
    .step  (sched_overrun),
    .count (overrun_count)
  );

  // ----------------------------------------
  // Event and read data
  // ----------------------------------------
  assign ownership_change_event = ownership_change_request;

  always_comb begin
    reg_rdata = HCS_REG_RESET;
    reg_rdata[HCS_SOC_MSB:HCS_SOC_LSB] = overrun_count;
    reg_rdata[HCS_OWN_REQ_BIT]     = ownership_change_request;
    reg_rdata[HCS_BULK_FILLED_BIT] = bulk_list_filled;
    reg_rdata[HCS_CTRL_FILLED_BIT] = control_list_filled;
    reg_rdata[HCS_RESET_BIT] = controller_soft_reset;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_srst_req;
    srst_start;
  endsequence

  sequence s_srst_clear;
    ##[1:500] !controller_soft_reset;
  endsequence

  a_srst_clears: assert property (@(posedge clk) disable iff (!rst_n)
    s_srst_req |=> controller_soft_reset ##0 s_srst_clear)
    else $error("soft reset bit not cleared in time");

  a_srst_suspend: assert property (@(posedge clk) disable iff (!rst_n)
    srst_start |=> suspended_state)
    else $error("soft reset did not suspend");

  a_soc_step: assert property (@(posedge clk) disable iff (!rst_n)
    (sched_overrun && !srst_done) |=> overrun_count == $past(overrun_count) + 2'h1)
    else $error("overrun count did not step");

  a_soc_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (sched_overrun && !srst_done && overrun_count == 2'h3) |=> overrun_count == 2'h0)
    else $error("overrun count did not wrap");

  a_soc_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!sched_overrun && !srst_done) |=> $stable(overrun_count))
    else $error("overrun count moved without event");

  a_own_event: assert property (@(posedge clk) disable iff (!rst_n)
    ownership_change_event == ownership_change_request)
    else $error("ownership event not following request");

  a_own_req_set: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_hit && reg_wdata[HCS_OWN_REQ_BIT] && !srst_done) |=> ownership_change_request)
    else $error("ownership request write lost");

  a_own_req_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (handover_done && !(wr_hit && reg_wdata[HCS_OWN_REQ_BIT])) |=> !ownership_change_request)
    else $error("ownership request not cleared");

  a_bulk_skip: assert property (@(posedge clk) disable iff (!rst_n)
    (bulk_list_start && !bulk_list_filled) |=> !bulk_list_process)
    else $error("empty bulk list processed");

  a_ctrl_run: assert property (@(posedge clk) disable iff (!rst_n)
    (control_list_start && control_list_filled) |=> control_list_process)
    else $error("filled control list skipped");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rdata[31:18] == 14'h0000 && reg_rdata[15:4] == 12'h000)
    else $error("reserved bits not zero");
endmodule : hcs_command_status

//--- design/hcs_pkg.sv
// Package: offsets, fields and timing constants of the command and status register
package hcs_pkg;
  localparam logic [31:0] HCS_BASE_CFG_OFFSET = 32'h0000_0010;
  localparam logic [7:0]  HCS_CMD_STATUS_OFF  = 8'h08;
  localparam int          HCS_RESET_BIT       = 0;
  localparam int          HCS_CTRL_FILLED_BIT = 1;
  localparam int          HCS_BULK_FILLED_BIT = 2;
  localparam int          HCS_OWN_REQ_BIT     = 3;
  localparam int          HCS_SOC_LSB         = 16;
  localparam int          HCS_SOC_MSB         = 17;
  localparam int          HCS_OWN_EVENT_BIT   = 30;
  localparam logic [1:0]  HCS_SOC_RESET       = 2'h0;
  localparam logic [31:0] HCS_REG_RESET       = 32'h0000_0000;
  localparam int          HCS_CLK_MHZ         = 50;
  localparam int          HCS_SRST_MAX_US     = 10;
  localparam int          HCS_SRST_CYCLES_RAW = HCS_SRST_MAX_US * HCS_CLK_MHZ;
  localparam logic [9:0]  HCS_SRST_CYCLES     = 10'(HCS_SRST_CYCLES_RAW);
  localparam logic [9:0]  HCS_SRST_WORK       = 10'h010;
endpackage : hcs_pkg

//--- design/hcs_wrap_counter.sv
// Two-bit wrapping event counter
`timescale 1ns/100ps
module hcs_wrap_counter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       step,
  output logic      [1:0] count
);
  import hcs_pkg::*;
  logic [1:0] next_count;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = HCS_SOC_RESET;
    end else if (step) begin
      // Wraps 11 to 00 rather than saturating
      next_count = count + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= HCS_SOC_RESET;
    end else begin
      count <= next_count;
    end
  end
endmodule : hcs_wrap_counter

//--- test/hcs_command_status_test.sv
// Self-checking bench for the host command and status register
`timescale 1ns/100ps
module hcs_command_status_test;
  import hcs_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        reg_sel;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        sched_overrun;
  logic        handover_done;
  logic        bulk_list_start;
  logic        bulk_td_found;
  logic        control_list_start;
  logic        control_td_found;
  logic        bulk_list_process;
  logic        control_list_process;
  logic        ownership_change_event;
  logic        soft_reset_active;
  logic        suspended_state;
  int          err_total;
  int          checks;

  hcs_command_status DUT (.clk, .rst_n, .reg_sel, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .sched_overrun, .handover_done, .bulk_list_start, .bulk_td_found, .control_list_start,
    .control_td_found, .bulk_list_process, .control_list_process, .ownership_change_event,
    .soft_reset_active, .suspended_state);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Called at a falling edge; strobe spans exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_sel = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_sel = 1'b0;
    reg_wr = 1'b0;
  endtask : wr

  // Touches only its own strobe, so back-to-back calls never reassign one signal
  task automatic pulse_list(input bit bulk, input bit td);
    case ({bulk, td})
      2'b11: bulk_td_found = 1'b1;
      2'b10: bulk_list_start = 1'b1;
      2'b01: control_td_found = 1'b1;
      default: control_list_start = 1'b1;
    endcase
    @(negedge clk);
    case ({bulk, td})
      2'b11: bulk_td_found = 1'b0;
      2'b10: bulk_list_start = 1'b0;
      2'b01: control_td_found = 1'b0;
      default: control_list_start = 1'b0;
    endcase
  endtask : pulse_list

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("reg after reset", reg_rdata, HCS_REG_RESET);
    chk("outputs after reset", 32'({ownership_change_event, soft_reset_active, suspended_state}), 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ownership;
    wr(8'h08, 32'h0000_0008);
    chk("request bit", reg_rdata, 32'h0000_0008);
    repeat (3) @(negedge clk);
    chk("event while requested", 32'(ownership_change_event), 32'h1);
    handover_done = 1'b1;
    @(negedge clk);
    handover_done = 1'b0;
    repeat (3) @(negedge clk);
    chk("request after handover", reg_rdata, 32'h0);
    chk("event after handover", 32'(ownership_change_event), 32'h0);
    $display("test ownership done");
  endtask : t_ownership

  task automatic t_list(input bit bulk);
    logic [31:0] f;
    f = 32'h1 << (bulk ? HCS_BULK_FILLED_BIT : HCS_CTRL_FILLED_BIT);
    pulse_list(bulk, 1'b0);
    chk("process on empty", 32'(bulk ? bulk_list_process : control_list_process), 32'h0);
    wr(8'h08, f);
    chk("flag written", reg_rdata, f);
    pulse_list(bulk, 1'b0);
    chk("process on filled", 32'(bulk ? bulk_list_process : control_list_process), 32'h1);
    chk("flag cleared at head", reg_rdata, 32'h0);
    pulse_list(bulk, 1'b1);
    chk("flag set on td", reg_rdata, f);
    wr(8'h08, 32'h0);
    chk("zero write ignored", reg_rdata, f);
    pulse_list(bulk, 1'b0);
    $display("test list %0d done", bulk);
  endtask : t_list

  task automatic t_reserved;
    wr(8'h08, 32'hffff_fff0);
    chk("reserved and count", reg_rdata, 32'h0);
    @(negedge clk);
    wr(8'h0c, 32'h0000_000e);
    chk("other offset", reg_rdata, 32'h0);
    $display("test reserved done");
  endtask : t_reserved

  // Held high for back-to-back overruns, crossing the wrap
  task automatic t_overrun;
    sched_overrun = 1'b1;
    for (int i = 1; i <= 5; i++) begin
      @(negedge clk);
      chk("overrun count", 32'(reg_rdata[17:16]), 32'(i % 4));
    end
    sched_overrun = 1'b0;
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_soft_reset;
    int n;
    wr(8'h08, 32'h0000_000e);
    @(negedge clk);
    wr(8'h08, 32'h0000_0001);
    chk("reset bit set", 32'({soft_reset_active, suspended_state}), 32'h3);
    chk("reg during reset", reg_rdata, 32'h0001_000f);
    n = 0;
    while (soft_reset_active !== 1'b0 && n < int'(HCS_SRST_CYCLES)) begin
      @(negedge clk);
      n++;
    end
    chk("reset within limit", 32'(n < int'(HCS_SRST_CYCLES)), 32'h1);
    chk("reg after soft reset", reg_rdata, 32'h0);
    chk("suspended kept", 32'(suspended_state), 32'h1);
    $display("test soft reset done");
  endtask : t_soft_reset

  initial begin
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    {reg_sel, reg_wr, sched_overrun, handover_done} = 4'h0;
    {bulk_list_start, bulk_td_found, control_list_start, control_td_found} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_ownership();
    t_list(1'b1);
    t_list(1'b0);
    t_reserved();
    t_overrun();
    t_soft_reset();
    tally_and_finish();
  end
endmodule : hcs_command_status_test
